/* design/irq_ctrl_pkg.sv */
// Shared constants for the interrupt controller: register map, field layout, resets
package irq_ctrl_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [10:0] IDX_LEVEL_SOURCE_ENABLE_0 = 11'h640;
   localparam logic [10:0] IDX_LEVEL_SOURCE_ENABLE_1 = 11'h641;
   localparam logic [10:0] IDX_EDGE_SOURCE_ENABLE = 11'h642;
   localparam logic [10:0] IDX_GLOBAL_IRQ_CONTROL = 11'h643;
   localparam logic [10:0] IDX_SOURCE_PRIORITY_0 = 11'h644;
   localparam logic [10:0] IDX_SOURCE_PRIORITY_1 = 11'h645;
   localparam logic [10:0] IDX_SOURCE_PRIORITY_2 = 11'h646;
   localparam logic [10:0] IDX_SOURCE_FLAGS_0 = 11'h648;
   localparam logic [10:0] IDX_SOURCE_FLAGS_1 = 11'h649;
   localparam logic [10:0] IDX_SOURCE_FLAGS_2 = 11'h64A;

   // Source counts and word layout
   localparam int NUM_SOURCES = 24;
   localparam int NUM_LEVEL = 16;
   localparam int NUM_EDGE = 8;
   localparam int SYNC_STAGES = 2;

   // Implemented source bits; reserved enable and flag positions hold no state and read zero
   localparam logic [7:0] LEVEL0_IMPL = 8'hF7;
   localparam logic [7:0] LEVEL1_IMPL = 8'hE0;
   localparam logic [7:0] EDGE_IMPL = 8'h7C;
   localparam logic [23:0] SOURCE_IMPL = {EDGE_IMPL, LEVEL1_IMPL, LEVEL0_IMPL};

   // Bit positions inside the 24-bit source word
   localparam int POS_TIMER_ZERO = 0;
   localparam int POS_TIMER_ONE = 1;
   localparam int POS_TIMER_TWO = 2;
   localparam int POS_DMA = 4;
   localparam int POS_DATA_QUEUE = 5;
   localparam int POS_SERIAL_PORT = 6;
   localparam int POS_HOST_CMD = 7;
   localparam int POS_RADIO_BASEBAND = 13;
   localparam int POS_PWM = 14;
   localparam int POS_PKE = 15;
   localparam int POS_PIN_EVENT = 18;
   localparam int POS_SLOW_TIMER_WAKE = 19;
   localparam int POS_SYSTEM_TICK = 20;
   localparam int POS_PIN_GROUP_0 = 21;
   localparam int POS_PIN_GROUP_1 = 22;

   // Control byte field
   localparam int GLOBAL_ENABLE_BIT = 0;

   // Reset values
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] PRIORITY_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h00000000;

endpackage

/* design/irq_sync.sv */
// Two-stage synchroniser bank for asynchronous request lines
`timescale 1ns/1ps
module irq_sync #(
   parameter int WIDTH = 24
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule // irq_sync

/* design/soc_interrupt_controller.sv */
// Interrupt controller: 24 sources, enable/priority/flag registers on Avalon-MM
// Overview of operation
// - Fifteen inputs: ten level, five edge, in 24 positions
// - Disabled source never requests the processor
// - Enable byte zero: host, serial, queue, DMA, timers
// - Enable byte one: PKE, pulse-width, radio baseband
// - Enable byte two: pin groups, tick, wake, event
// - Global enable bit gates every request
// - Control bit one reserved, no effect
// - Priority bytes: one marks high priority
// - High-priority group presented ahead of low
// - Flag bytes show which sources requested
// - Flags form one 24-bit word, byte zero low
// - Edge flags latched until written one
// - Level flags follow source, cleared at source
`timescale 1ns/1ps
module soc_interrupt_controller (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Avalon-MM slave, byte addressed
   input wire logic [12:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Level-sensitive sources
   input wire logic timer_zero_request_i,
   input wire logic timer_one_request_i,
   input wire logic timer_two_request_i,
   input wire logic dma_request_i,
   input wire logic data_queue_request_i,
   input wire logic serial_port_request_i,
   input wire logic host_cmd_request_i,
   input wire logic radio_baseband_request_i,
   input wire logic pwm_request_i,
   input wire logic pke_request_i,
   // Edge-sensitive sources
   input wire logic pin_event_request_i,
   input wire logic slow_timer_wake_request_i,
   input wire logic system_tick_request_i,
   input wire logic [1:0] pin_group_request_i,
   // To the processor core
   output logic irq_request_o,
   output logic irq_high_priority_o,
   output logic irq_low_priority_o
);

   // Register storage
   logic [7:0] level_source_enable_0;
   logic [7:0] level_source_enable_1;
   logic [7:0] edge_source_enable;
   logic [7:0] global_irq_control;
   logic [7:0] source_priority_0;
   logic [7:0] source_priority_1;
   logic [7:0] source_priority_2;
   logic [7:0] edge_flags;

   // Source word assembly and synchronisation
   logic [23:0] raw_sources;
   logic [23:0] sync_sources;
   logic [7:0] edge_prev;
   logic [7:0] edge_rise;
   logic [15:0] level_flags;
   logic [23:0] source_flags;
   logic [23:0] source_enable;
   logic [23:0] source_priority;
   logic [23:0] pending;
   logic global_enable;

   // Bus handshake
   logic access;
   logic wr_strobe;
   logic [10:0] word_index;
   logic [31:0] next_readdata;
   logic [7:0] wr_byte;

   // Matches the bus index against one register
   function automatic logic hit(input logic [10:0] idx, input logic [10:0] reg_idx);
      hit = (idx == reg_idx);
   endfunction

   // Place the request pins into the 24-bit source word
   always_comb begin
      raw_sources = 24'h000000;
      raw_sources[irq_ctrl_pkg::POS_TIMER_ZERO] = timer_zero_request_i;
      raw_sources[irq_ctrl_pkg::POS_TIMER_ONE] = timer_one_request_i;
      raw_sources[irq_ctrl_pkg::POS_TIMER_TWO] = timer_two_request_i;
      raw_sources[irq_ctrl_pkg::POS_DMA] = dma_request_i;
      raw_sources[irq_ctrl_pkg::POS_DATA_QUEUE] = data_queue_request_i;
      raw_sources[irq_ctrl_pkg::POS_SERIAL_PORT] = serial_port_request_i;
      raw_sources[irq_ctrl_pkg::POS_HOST_CMD] = host_cmd_request_i;
      raw_sources[irq_ctrl_pkg::POS_RADIO_BASEBAND] = radio_baseband_request_i;
      raw_sources[irq_ctrl_pkg::POS_PWM] = pwm_request_i;
      raw_sources[irq_ctrl_pkg::POS_PKE] = pke_request_i;
      raw_sources[irq_ctrl_pkg::POS_PIN_EVENT] = pin_event_request_i;
      raw_sources[irq_ctrl_pkg::POS_SLOW_TIMER_WAKE] = slow_timer_wake_request_i;
      raw_sources[irq_ctrl_pkg::POS_SYSTEM_TICK] = system_tick_request_i;
      raw_sources[irq_ctrl_pkg::POS_PIN_GROUP_0] = pin_group_request_i[0];
      raw_sources[irq_ctrl_pkg::POS_PIN_GROUP_1] = pin_group_request_i[1];
   end

   // Source lines come from other logic blocks or pins; synchronise all of them
   irq_sync #(
      .WIDTH(irq_ctrl_pkg::NUM_SOURCES)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i(raw_sources),
      .sync_o(sync_sources)
   );

   // Previous sample of edge sources for rise detection
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         edge_prev <= irq_ctrl_pkg::FLAGS_RESET;
      end else begin
         edge_prev <= sync_sources[23:16];
      end
   end

   assign edge_rise = sync_sources[23:16] & ~edge_prev & irq_ctrl_pkg::EDGE_IMPL;

   // Level flags track the synchronised line; no clear exists here
   assign level_flags = sync_sources[15:0]
      & {irq_ctrl_pkg::LEVEL1_IMPL, irq_ctrl_pkg::LEVEL0_IMPL};

   assign source_flags = {edge_flags, level_flags};
   assign source_enable = {edge_source_enable, level_source_enable_1,
      level_source_enable_0};
   assign source_priority = {source_priority_2, source_priority_1, source_priority_0};
   assign global_enable = global_irq_control[irq_ctrl_pkg::GLOBAL_ENABLE_BIT];
   assign pending = source_flags & source_enable;

   // Bus decode; the low two address bits select nothing
   assign word_index = avs_address_i[12:2];
   assign access = avs_read_i | avs_write_i;
   assign wr_strobe = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
   assign wr_byte = avs_writedata_i[7:0];

   // One wait state: waitrequest drops for exactly one cycle per request
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (access && avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // Read mux; unmapped addresses and reserved enable, control and flag bits read zero
   always_comb begin
      next_readdata = irq_ctrl_pkg::READ_ZERO;
      if (hit(word_index, irq_ctrl_pkg::IDX_LEVEL_SOURCE_ENABLE_0)) begin
         next_readdata[7:0] = level_source_enable_0;
      end else if (hit(word_index, irq_ctrl_pkg::IDX_LEVEL_SOURCE_ENABLE_1)) begin
         next_readdata[7:0] = level_source_enable_1;
      end else if (hit(word_index, irq_ctrl_pkg::IDX_EDGE_SOURCE_ENABLE)) begin
         next_readdata[7:0] = edge_source_enable;
      end else if (hit(word_index, irq_ctrl_pkg::IDX_GLOBAL_IRQ_CONTROL)) begin
         next_readdata[7:0] = global_irq_control;
      end else if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_PRIORITY_0)) begin
         next_readdata[7:0] = source_priority_0;
      end else if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_PRIORITY_1)) begin
         next_readdata[7:0] = source_priority_1;
      end else if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_PRIORITY_2)) begin
         next_readdata[7:0] = source_priority_2;
      end else if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_FLAGS_0)) begin
         next_readdata[7:0] = source_flags[7:0];
      end else if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_FLAGS_1)) begin
         next_readdata[7:0] = source_flags[15:8];
      end else if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_FLAGS_2)) begin
         next_readdata[7:0] = source_flags[23:16];
      end
   end

   // Read data captured as waitrequest falls, so it stands at the accept edge
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         avs_readdata_o <= irq_ctrl_pkg::READ_ZERO;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= next_readdata;
      end
   end

   // Enable bytes; reserved positions never store a one
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         level_source_enable_0 <= irq_ctrl_pkg::ENABLE_RESET;
         level_source_enable_1 <= irq_ctrl_pkg::ENABLE_RESET;
         edge_source_enable <= irq_ctrl_pkg::ENABLE_RESET;
      end else if (wr_strobe) begin
         if (hit(word_index, irq_ctrl_pkg::IDX_LEVEL_SOURCE_ENABLE_0)) begin
            level_source_enable_0 <= wr_byte & irq_ctrl_pkg::LEVEL0_IMPL;
         end
         if (hit(word_index, irq_ctrl_pkg::IDX_LEVEL_SOURCE_ENABLE_1)) begin
            level_source_enable_1 <= wr_byte & irq_ctrl_pkg::LEVEL1_IMPL;
         end
         if (hit(word_index, irq_ctrl_pkg::IDX_EDGE_SOURCE_ENABLE)) begin
            edge_source_enable <= wr_byte & irq_ctrl_pkg::EDGE_IMPL;
         end
      end
   end

   // Control byte: only the global enable is kept, bit one is ignored
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         global_irq_control <= irq_ctrl_pkg::CONTROL_RESET;
      end else if (wr_strobe && hit(word_index, irq_ctrl_pkg::IDX_GLOBAL_IRQ_CONTROL)) begin
         global_irq_control <= {7'h00, wr_byte[irq_ctrl_pkg::GLOBAL_ENABLE_BIT]};
      end
   end

   // Priority bytes stay fully writable, though software leaves them alone
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         source_priority_0 <= irq_ctrl_pkg::PRIORITY_RESET;
         source_priority_1 <= irq_ctrl_pkg::PRIORITY_RESET;
         source_priority_2 <= irq_ctrl_pkg::PRIORITY_RESET;
      end else if (wr_strobe) begin
         if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_PRIORITY_0)) begin
            source_priority_0 <= wr_byte;
         end
         if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_PRIORITY_1)) begin
            source_priority_1 <= wr_byte;
         end
         if (hit(word_index, irq_ctrl_pkg::IDX_SOURCE_PRIORITY_2)) begin
            source_priority_2 <= wr_byte;
         end
      end
   end

   // Edge flags: a rise in the clearing cycle wins, so no event is lost
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         edge_flags <= irq_ctrl_pkg::FLAGS_RESET;
      end else if (wr_strobe && hit(word_index, irq_ctrl_pkg::IDX_SOURCE_FLAGS_2)) begin
         edge_flags <= (edge_flags & ~wr_byte) | edge_rise;
      end else begin
         edge_flags <= edge_flags | edge_rise;
      end
   end

   // Request and priority indication to the core, registered
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_request_o <= 1'b0;
         irq_high_priority_o <= 1'b0;
         irq_low_priority_o <= 1'b0;
      end else begin
         irq_request_o <= global_enable & (|pending);
         // High group shown whenever global enable is set and any high source is pending
         irq_high_priority_o <= global_enable & (|(pending & source_priority));
         // Low group only surfaces once no high source remains
         irq_low_priority_o <= global_enable & (|(pending & ~source_priority))
            & ~(|(pending & source_priority));
      end
   end

endmodule // soc_interrupt_controller

/* sim/irq_core_model.sv */
// Behavioural processor core: records which priority group it is asked to serve
`timescale 1ns/1ps
module irq_core_model (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic irq_request_i,
   input wire logic irq_high_priority_i,
   input wire logic irq_low_priority_i,
   output logic [1:0] serve_level_o
);
   // High group is served first, so it wins when both show
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !irq_request_i) begin
         serve_level_o <= 2'h0;
      end else begin
         serve_level_o <= irq_high_priority_i ? 2'h2 : {1'b0, irq_low_priority_i};
      end
   end
endmodule // irq_core_model

/* sim/irq_ctrl_assertions.sv */
// Port-level checker for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_checker (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [12:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic timer_zero_request_i,
   input wire logic irq_request_o,
   input wire logic irq_high_priority_o,
   input wire logic irq_low_priority_o
);
   logic global_on;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Shadow of the global enable, the register itself is not visible here
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         global_on <= 1'b0;
      end else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
            avs_address_i[12:2] == irq_ctrl_pkg::IDX_GLOBAL_IRQ_CONTROL) begin
         global_on <= avs_writedata_i[0];
      end
   end
   // Steps of a flag read while timer zero stays high
   sequence s_zero_held;
      timer_zero_request_i [*5];
   endsequence
   sequence s_flag0_read;
      avs_read_i && !avs_waitrequest_o && avs_address_i[12:2] == irq_ctrl_pkg::IDX_SOURCE_FLAGS_0;
   endsequence
   a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("waitrequest not low after one wait cycle");
   a_wait_released: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_idle_wait_high: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("waitrequest low without a request");
   a_read_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_prio_exclusive: assert property (!(irq_high_priority_o && irq_low_priority_o))
      else $error("both priority groups shown");
   a_request_has_prio: assert property (irq_request_o |-> irq_high_priority_o || irq_low_priority_o)
      else $error("request without a priority group");
   a_global_gate: assert property (!global_on |=> !irq_request_o)
      else $error("request while global enable is off");
   a_level_flag_read: assert property (s_zero_held ##0 s_flag0_read |-> avs_readdata_o[0])
      else $error("timer zero flag not read as set");
endmodule // irq_ctrl_checker

bind soc_interrupt_controller irq_ctrl_checker chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .timer_zero_request_i(timer_zero_request_i), .irq_request_o(irq_request_o),
   .irq_high_priority_o(irq_high_priority_o), .irq_low_priority_o(irq_low_priority_o));

/* sim/test_soc_interrupt_controller.sv */
// Register-level testbench for the interrupt controller
`timescale 1ns/1ps
module test_soc_interrupt_controller;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [12:0] addr = 13'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wreq;
   logic [23:0] src = 24'h0;
   logic irq, hi, lo;
   logic [1:0] level;
   logic [31:0] q;
   int num_errors = 0;
   int num_checks = 0;
   logic [3:0] be = 4'hF;
   logic [10:0] idx [10] = '{11'h640, 11'h641, 11'h642, 11'h643, 11'h644, 11'h645,
      11'h646, 11'h648, 11'h649, 11'h647};
   logic [7:0] wval [10] = '{8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hF7, 8'hE0, 8'h7C, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] rval [10] = '{8'hF7, 8'hE0, 8'h7C, 8'h01, 8'hF7, 8'hE0, 8'h7C, 8'h00, 8'h00, 8'h00};
   soc_interrupt_controller dut (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .timer_zero_request_i(src[0]),
      .timer_one_request_i(src[1]), .timer_two_request_i(src[2]), .dma_request_i(src[4]),
      .data_queue_request_i(src[5]), .serial_port_request_i(src[6]), .host_cmd_request_i(src[7]),
      .radio_baseband_request_i(src[13]), .pwm_request_i(src[14]), .pke_request_i(src[15]),
      .pin_event_request_i(src[18]), .slow_timer_wake_request_i(src[19]),
      .system_tick_request_i(src[20]), .pin_group_request_i(src[22:21]),
      .irq_request_o(irq), .irq_high_priority_o(hi), .irq_low_priority_o(lo));
   irq_core_model core (.sys_clk_i(clk), .rst_i(rst), .irq_request_i(irq),
      .irq_high_priority_i(hi), .irq_low_priority_i(lo), .serve_level_o(level));
   // Free-running system clock
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic results();
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One bus cycle held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input bit w, input logic [10:0] i, input logic [7:0] d);
      @(posedge clk);
      addr <= {i, 2'b00};
      wr <= w;
      rd <= !w;
      wdata <= {24'h0, d};
      // Only the watchdog ends a wait that never sees waitrequest low
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rchk(input string name, input logic [10:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      chk(name, q, {24'h0, e});
   endtask
   // Outputs to the core after a fixed settling span; irq is registered
   task automatic ichk(input logic [2:0] e);
      repeat (6) @(posedge clk);
      chk("irq_hi_lo", {29'h0, irq, hi, lo}, {29'h0, e});
   endtask
   // Bounded run: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 10; k++) rchk("reset", idx[k], 8'h00);
      rchk("flags2_reset", 11'h64A, 8'h00);
      // Reserved bits, read-only flags and the unmapped slot keep nothing
      for (int k = 0; k < 10; k++) begin
         bus(1'b1, idx[k], wval[k]);
         rchk("readback", idx[k], rval[k]);
         bus(1'b1, idx[k], 8'h00);
      end
      // Write with lane zero disabled must not land
      be <= 4'hE;
      bus(1'b1, 11'h640, 8'hFF);
      be <= 4'hF;
      rchk("lane0_off", 11'h640, 8'h00);
      bus(1'b1, 11'h643, 8'h01);
      src[0] <= 1'b1;
      ichk(3'b000);
      rchk("flags0", 11'h648, 8'h01);
      bus(1'b1, 11'h640, 8'h01);
      ichk(3'b101);
      chk("core_level", {30'h0, level}, 32'h1);
      bus(1'b1, 11'h644, 8'h01);
      ichk(3'b110);
      src[15] <= 1'b1;
      bus(1'b1, 11'h641, 8'h80);
      ichk(3'b110);
      chk("core_level", {30'h0, level}, 32'h2);
      rchk("flags1", 11'h649, 8'h80);
      src[0] <= 1'b0;
      ichk(3'b101);
      rchk("flags0_follow", 11'h648, 8'h00);
      bus(1'b1, 11'h644, 8'h00);
      rchk("prio0_restored", 11'h644, 8'h00);
      bus(1'b1, 11'h643, 8'h02);
      repeat (6) @(posedge clk);
      chk("irq_gated", {31'h0, irq}, 32'h0);
      src[15] <= 1'b0;
      // Each edge source: latch, survive a zero write, clear on a one write
      for (int p = 18; p < 23; p++) begin
         bus(1'b1, 11'h642, 8'h01 << (p - 16));
         bus(1'b1, 11'h643, 8'h01);
         src[p] <= 1'b1;
         ichk(3'b101);
         rchk("edge_set", 11'h64A, 8'h01 << (p - 16));
         src[p] <= 1'b0;
         bus(1'b1, 11'h64A, 8'h00);
         rchk("edge_held", 11'h64A, 8'h01 << (p - 16));
         bus(1'b1, 11'h64A, 8'h01 << (p - 16));
         rchk("edge_clear", 11'h64A, 8'h00);
         ichk(3'b000);
      end
      // Second reset mid-run, with enables set and one edge flag latched
      src[20] <= 1'b1;
      repeat (6) @(posedge clk);
      src[20] <= 1'b0;
      rchk("edge_before_rst", 11'h64A, 8'h10);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("irq_reset2", {29'h0, irq, hi, lo}, 32'h0);
      for (int k = 0; k < 10; k++) rchk("reset2", idx[k], 8'h00);
      rchk("flags2_reset2", 11'h64A, 8'h00);
      results();
   end
endmodule // test_soc_interrupt_controller
